// ### vncb_pkg.sv
// shared constants for the node register bank
package vncb_pkg;
  localparam logic [4:0] OFF_LOOPBACK   = 5'h00;
  localparam logic [4:0] OFF_LOCAL_CMD  = 5'h01;
  localparam logic [4:0] OFF_LOCAL_STAT = 5'h03;
  localparam logic [4:0] OFF_DMA_AM     = 5'h04;
  localparam logic [4:0] OFF_IRQ_VEC    = 5'h07;
  localparam logic [4:0] OFF_REMOTE_CMD = 5'h09;
  localparam logic [4:0] OFF_FAR_IDENT  = 5'h0D;
  localparam logic [4:0] OFF_MAP_RAM    = 5'h0F;
  localparam logic [1:0] GRP_LOCAL_NODE  = 2'h0;
  localparam logic [1:0] GRP_REMOTE_NODE = 2'h1;
  localparam logic [1:0] GRP_LOCAL_DMA   = 2'h2;
  localparam logic [1:0] GRP_REMOTE_DMA  = 2'h3;
  localparam int LB_REMOTE = 1;
  localparam int LB_LOCAL  = 0;
  localparam int LC_CLR_ERR   = 7;
  localparam int LC_CLR_INB   = 6;
  localparam int LC_SEND_OUT  = 5;
  localparam int LC_BLK_VME   = 4;
  localparam int LC_BLK_PCI   = 2;
  localparam int LS_FIBER_ERR = 7;
  localparam int LS_RBUS_ERR  = 6;
  localparam int LS_INB_DB    = 5;
  localparam int LS_TIMEOUT   = 2;
  localparam int LS_OUT_DB    = 1;
  localparam int LS_LINK_OFF  = 0;
  localparam int RC_CLR_PAR   = 7;
  localparam int RC_CLR_DB    = 6;
  localparam int RC_SEND_DB   = 5;
  localparam int RS_SEND_ACT  = 5;
  localparam int RS_PAR_ERR   = 3;
  localparam int RS_RECV_ACT  = 1;
  localparam logic [7:0] LOCAL_CMD_MASK  = 8'h34;
  localparam logic [7:0] LOOPBACK_MASK   = 8'h03;
  localparam logic [7:0] IRQ_VEC_RESET   = 8'hFF;
  localparam logic [7:0] RESET_ZERO      = 8'h00;
  // arbitrary neutral identification value
  localparam logic [7:0] FAR_IDENT_VALUE = 8'h5A;
  localparam int CLK_HZ       = 25000000;
  localparam int DMA_TMO_MS   = 16;
  localparam int REM_TMO_MS   = 30;
  localparam int DMA_TMO_CYC  = CLK_HZ / 1000 * DMA_TMO_MS;
  localparam int REM_TMO_CYC  = CLK_HZ / 1000 * REM_TMO_MS;
endpackage

// ### vncb_sticky.sv
// one sticky flag: set beats clear
`timescale 1ns/1ps
module vncb_sticky
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  logic flag_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      flag_reg <= 1'b0;
    else if (set)
      flag_reg <= 1'b1;
    else if (clr)
      flag_reg <= 1'b0;
  assign flag = flag_reg;
endmodule

// ### vncb_timer.sv
// watchdog for one pending operation
`timescale 1ns/1ps
module vncb_timer
#(
  parameter int LIMIT = 400000
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic busy,
  output logic      expired
);
  logic [31:0] cnt_reg;
  logic        exp_reg;
  logic        hit;
  assign hit = busy && (cnt_reg == 32'(LIMIT - 1));
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_reg <= 32'h0;
      exp_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= (busy && !hit) ? cnt_reg + 32'h1 : 32'h0;
      exp_reg <= hit;
    end
  assign expired = exp_reg;
endmodule

// ### vncb_bank.sv
// node control and status register bank facing the backplane
// Function
// - window splits into four 8-byte groups: local, remote, local DMA, remote DMA
// - loopback bit1 steers remote window to remote reg, bit0 to local reg
// - no DMA while any loopback is enabled
// - error flags stay set until command bit 7 written one; write-only bit
// - command bit 6 clears only the incoming doorbell status flag
// - command bit 5 held one drives outgoing doorbell over cable
// - command bit 4 blocks all interrupts onto the backplane
// - command bit 2 blocks interrupts toward the far adapter
// - status bit 7 latches fiber data error until clear-errors
// - status bit 6 latches remote bus errors until clear-errors
// - status bit 5 latches incoming doorbell until command bit 6
// - status bit 2 latches DMA 16 ms or remote 30 ms timeout
// - status bit 1 shows outgoing doorbell until far side acknowledges or command bit 5 drops
// - status bit 0 shows remote power or cable off, live
// - modifier register drives bus modifier only during DMA
// - acknowledge cycle returns vector register, reset to FF
// - remote command bit 7 clears remote parity error
// - remote command bit 6 clears far doorbell toward backplane
// - remote command bit 5 raises doorbell toward far bus
// - reads at remote command offset return remote status
// - ident register returns fixed code, ignores writes
`timescale 1ns/1ps
module vncb_bank
#(
  parameter int DMA_TMO = vncb_pkg::DMA_TMO_CYC,
  parameter int REM_TMO = vncb_pkg::REM_TMO_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       fiber_err_pin,
  input  wire logic       rbus_err_pin,
  input  wire logic       inb_doorbell_pin,
  input  wire logic       out_doorbell_ack_pin,
  input  wire logic       link_off_pin,
  input  wire logic       remote_par_err_pin,
  input  wire logic       far_doorbell_pin,
  input  wire logic       dma_busy,
  input  wire logic       remote_busy,
  input  wire logic       dma_start_req,
  output logic            dma_start_ok,
  input  wire logic       ram_window_access,
  output logic            ram_to_remote_reg,
  output logic            ram_to_local_reg,
  output logic            ram_to_pci,
  output logic      [7:0] vme_am_out,
  output logic            vme_am_drive,
  input  wire logic       vme_irq_req,
  output logic            vme_irq_out,
  input  wire logic       iack_cycle,
  output logic      [7:0] iack_vector,
  input  wire logic       pci_irq_req,
  output logic            pci_irq_out,
  output logic            out_doorbell_req,
  output logic            vme_to_pci_doorbell,
  output logic            far_card_clear_db,
  output logic            far_card_clear_par,
  output logic      [7:0] map_ram_ctl
);
  // pin synchronisers, stage one feeds stage two only
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] pins;
  assign pins = {far_doorbell_pin, remote_par_err_pin, link_off_pin,
                 out_doorbell_ack_pin, inb_doorbell_pin, rbus_err_pin, fiber_err_pin};
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  logic s_fiber;
  logic s_rbus;
  logic s_inb;
  logic s_ack;
  logic s_off;
  logic s_rpar;
  logic s_fdb;
  assign {s_fdb, s_rpar, s_off, s_ack, s_inb, s_rbus, s_fiber} = sync2_reg;

  // address decode
  logic [1:0] grp;
  logic       wr_loop;
  logic       wr_lcmd;
  logic       wr_am;
  logic       wr_vec;
  logic       wr_rcmd;
  logic       wr_map;
  assign grp     = reg_addr[4:3];
  logic       node_grp;
  assign node_grp = (grp == vncb_pkg::GRP_LOCAL_NODE)
                    || (grp == vncb_pkg::GRP_REMOTE_NODE);
  assign wr_loop = reg_wr && reg_addr == vncb_pkg::OFF_LOOPBACK;
  assign wr_lcmd = reg_wr && reg_addr == vncb_pkg::OFF_LOCAL_CMD;
  assign wr_am   = reg_wr && reg_addr == vncb_pkg::OFF_DMA_AM;
  assign wr_vec  = reg_wr && reg_addr == vncb_pkg::OFF_IRQ_VEC;
  assign wr_rcmd = reg_wr && reg_addr == vncb_pkg::OFF_REMOTE_CMD;
  assign wr_map  = reg_wr && reg_addr == vncb_pkg::OFF_MAP_RAM;

  logic [7:0] loopback_reg;
  logic [7:0] lcmd_reg;
  logic [7:0] am_reg;
  logic [7:0] vec_reg;
  logic       send_db_reg;
  logic [7:0] map_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      loopback_reg <= vncb_pkg::RESET_ZERO;
      lcmd_reg     <= vncb_pkg::RESET_ZERO;
      am_reg       <= vncb_pkg::RESET_ZERO;
      vec_reg      <= vncb_pkg::IRQ_VEC_RESET;
      send_db_reg  <= 1'b0;
      map_reg      <= vncb_pkg::RESET_ZERO;
    end
    else
    begin
      if (wr_loop)
        loopback_reg <= reg_wdata & vncb_pkg::LOOPBACK_MASK;
      if (wr_lcmd)
        lcmd_reg <= reg_wdata & vncb_pkg::LOCAL_CMD_MASK;
      if (wr_am)
        am_reg <= reg_wdata;
      if (wr_vec)
        vec_reg <= reg_wdata;
      if (wr_rcmd)
        send_db_reg <= reg_wdata[vncb_pkg::RC_SEND_DB];
      if (wr_map)
        map_reg <= reg_wdata;
    end

  // write-only command strobes
  logic clr_err;
  logic clr_inb;
  assign clr_err = wr_lcmd && reg_wdata[vncb_pkg::LC_CLR_ERR];
  assign clr_inb = wr_lcmd && reg_wdata[vncb_pkg::LC_CLR_INB];
  assign far_card_clear_par = wr_rcmd && reg_wdata[vncb_pkg::RC_CLR_PAR];
  assign far_card_clear_db  = wr_rcmd && reg_wdata[vncb_pkg::RC_CLR_DB];

  // timeouts
  logic dma_exp;
  logic rem_exp;
  vncb_timer #(.LIMIT(DMA_TMO)) u_dma_tmo
  (
    .clk    (clk),
    .rst    (rst),
    .busy   (dma_busy),
    .expired(dma_exp)
  );
  vncb_timer #(.LIMIT(REM_TMO)) u_rem_tmo
  (
    .clk    (clk),
    .rst    (rst),
    .busy   (remote_busy),
    .expired(rem_exp)
  );

  // sticky status flags; set beats clear
  logic [3:0] st_set;
  logic [3:0] st_clr;
  logic [3:0] st_q;
  // cable down: remote attempts fail as bus errors instead of waiting out the timer
  logic link_err;
  assign link_err = s_off && (remote_busy || dma_busy);
  assign st_set = {s_fiber, s_rbus || link_err, s_inb, dma_exp || rem_exp};
  assign st_clr = {clr_err, clr_err, clr_inb, clr_err};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_st
      vncb_sticky u_st
      (
        .clk (clk),
        .rst (rst),
        .set (st_set[gi]),
        .clr (st_clr[gi]),
        .flag(st_q[gi])
      );
    end
  endgenerate

  // outbound doorbell status active until acknowledged or command bit 5 drops; request follows command bit 5
  logic out_db_reg;
  logic send_rise;
  logic send_prev_reg;
  assign send_rise = lcmd_reg[vncb_pkg::LC_SEND_OUT] && !send_prev_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      out_db_reg    <= 1'b0;
      send_prev_reg <= 1'b0;
    end
    else
    begin
      send_prev_reg <= lcmd_reg[vncb_pkg::LC_SEND_OUT];
      if (send_rise)
        out_db_reg <= 1'b1;
      else if (s_ack || !lcmd_reg[vncb_pkg::LC_SEND_OUT])
        out_db_reg <= 1'b0;
    end
  assign out_doorbell_req = lcmd_reg[vncb_pkg::LC_SEND_OUT];

  logic [7:0] lstat;
  assign lstat = {st_q[3], st_q[2], st_q[1], 2'b00, st_q[0], out_db_reg, s_off};
  logic [7:0] rstat;
  assign rstat = {2'b00, send_db_reg, 1'b0, s_rpar, 1'b0, s_fdb, 1'b0};

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  assign rd_mux = !node_grp                              ? vncb_pkg::RESET_ZERO :
                  (reg_addr == vncb_pkg::OFF_LOOPBACK)   ? loopback_reg :
                  (reg_addr == vncb_pkg::OFF_LOCAL_CMD)  ? lcmd_reg :
                  (reg_addr == vncb_pkg::OFF_LOCAL_STAT) ? lstat :
                  (reg_addr == vncb_pkg::OFF_DMA_AM)     ? am_reg :
                  (reg_addr == vncb_pkg::OFF_IRQ_VEC)    ? vec_reg :
                  (reg_addr == vncb_pkg::OFF_REMOTE_CMD) ? rstat :
                  (reg_addr == vncb_pkg::OFF_FAR_IDENT)  ? vncb_pkg::FAR_IDENT_VALUE :
                  (reg_addr == vncb_pkg::OFF_MAP_RAM)    ? map_reg :
                  vncb_pkg::RESET_ZERO;
  logic [7:0] rdata_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rdata_reg <= 8'h00;
    else if (reg_rd)
      rdata_reg <= rd_mux;
  assign reg_rdata = rdata_reg;

  // loopback steering
  logic any_loop;
  assign any_loop = loopback_reg[vncb_pkg::LB_REMOTE] || loopback_reg[vncb_pkg::LB_LOCAL];
  assign ram_to_remote_reg = ram_window_access && loopback_reg[vncb_pkg::LB_REMOTE];
  assign ram_to_local_reg  = ram_window_access && !loopback_reg[vncb_pkg::LB_REMOTE]
                             && loopback_reg[vncb_pkg::LB_LOCAL];
  assign ram_to_pci        = ram_window_access && !any_loop;
  assign dma_start_ok      = dma_start_req && !any_loop;

  // bus modifier and interrupt gating
  // enable lags busy together with the code, so a driven modifier is never a stale zero
  logic [7:0] am_q;
  logic       am_drv_q;
  logic [7:0] vec_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      am_q     <= 8'h00;
      am_drv_q <= 1'b0;
      vec_q    <= 8'h00;
    end
    else
    begin
      am_q     <= dma_busy ? am_reg : 8'h00;
      am_drv_q <= dma_busy;
      vec_q    <= iack_cycle ? vec_reg : 8'h00;
    end
  assign vme_am_out   = am_q;
  assign vme_am_drive = am_drv_q;
  assign iack_vector  = vec_q;
  assign vme_irq_out  = vme_irq_req && !lcmd_reg[vncb_pkg::LC_BLK_VME];
  assign pci_irq_out  = pci_irq_req && !lcmd_reg[vncb_pkg::LC_BLK_PCI];
  assign vme_to_pci_doorbell = send_db_reg;
  assign map_ram_ctl  = map_reg;

  // checks
  a_err_sticky: assert property (@(posedge clk) disable iff (rst)
    st_q[3] && !clr_err |=> st_q[3]) else $error("fiber error flag dropped");
  a_clr_err: assert property (@(posedge clk) disable iff (rst)
    clr_err && !s_fiber |=> !st_q[3]) else $error("clear errors failed");
  a_rbus_set: assert property (@(posedge clk) disable iff (rst)
    s_rbus |=> st_q[2]) else $error("bus error not latched");
  a_inb_clear: assert property (@(posedge clk) disable iff (rst)
    clr_inb && !s_inb |=> !st_q[1]) else $error("doorbell not cleared");
  a_vme_block: assert property (@(posedge clk) disable iff (rst)
    lcmd_reg[vncb_pkg::LC_BLK_VME] |-> !vme_irq_out) else $error("backplane irq leak");
  a_pci_block: assert property (@(posedge clk) disable iff (rst)
    lcmd_reg[vncb_pkg::LC_BLK_PCI] |-> !pci_irq_out) else $error("far irq leak");
  a_dma_loop: assert property (@(posedge clk) disable iff (rst)
    any_loop |-> !dma_start_ok) else $error("dma in loopback");
  a_am_drive: assert property (@(posedge clk) disable iff (rst)
    !$past(dma_busy) |-> vme_am_out == 8'h00) else $error("modifier outside dma");
  a_rstat_send: assert property (@(posedge clk) disable iff (rst)
    rstat[vncb_pkg::RS_SEND_ACT] == vme_to_pci_doorbell) else $error("status mismatch");
  a_iack_vec: assert property (@(posedge clk) disable iff (rst)
    iack_cycle |=> iack_vector == $past(vec_reg)) else $error("wrong vector");
  c_clear_err: cover property (@(posedge clk) disable iff (rst) st_q[3] ##1 clr_err);
  c_doorbell:  cover property (@(posedge clk) disable iff (rst) send_rise ##[1:20] s_ack);
  c_timeout:   cover property (@(posedge clk) disable iff (rst) dma_exp);
  c_loopback:  cover property (@(posedge clk) disable iff (rst) ram_to_remote_reg);
  c_link_err:  cover property (@(posedge clk) disable iff (rst) link_err);
  // status flag checks
  a_fiber_set: assert property (@(posedge clk) disable iff (rst)
    s_fiber |=> st_q[3]) else $error("fiber error not latched");
  a_rbus_sticky: assert property (@(posedge clk) disable iff (rst)
    st_q[2] && !clr_err |=> st_q[2]) else $error("bus error flag dropped");
  a_inb_sticky: assert property (@(posedge clk) disable iff (rst)
    st_q[1] && !clr_inb |=> st_q[1]) else $error("doorbell flag dropped");
  a_tmo_set: assert property (@(posedge clk) disable iff (rst)
    dma_exp || rem_exp |=> st_q[0]) else $error("timeout not latched");
  a_tmo_sticky: assert property (@(posedge clk) disable iff (rst)
    st_q[0] && !clr_err |=> st_q[0]) else $error("timeout flag dropped");
  a_link_err: assert property (@(posedge clk) disable iff (rst)
    link_err |=> st_q[2]) else $error("cable down access not flagged");
  a_out_db_set: assert property (@(posedge clk) disable iff (rst)
    send_rise |=> out_db_reg) else $error("outgoing doorbell not shown");
  a_out_db_ack: assert property (@(posedge clk) disable iff (rst)
    s_ack && !send_rise |=> !out_db_reg) else $error("doorbell ack ignored");
  // steering, read path and output checks
  a_loop_remote: assert property (@(posedge clk) disable iff (rst)
    ram_window_access && loopback_reg[vncb_pkg::LB_REMOTE] |-> ram_to_remote_reg
    && !ram_to_local_reg && !ram_to_pci) else $error("remote loopback misrouted");
  a_pci_path: assert property (@(posedge clk) disable iff (rst)
    ram_to_pci |-> !ram_to_remote_reg && !ram_to_local_reg) else $error("double target");
  a_dma_free: assert property (@(posedge clk) disable iff (rst)
    dma_start_req && !any_loop |-> dma_start_ok) else $error("dma start refused");
  a_vme_pass: assert property (@(posedge clk) disable iff (rst)
    vme_irq_req && !lcmd_reg[vncb_pkg::LC_BLK_VME] |-> vme_irq_out) else $error("irq lost");
  a_ident_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == vncb_pkg::OFF_FAR_IDENT |=> reg_rdata == vncb_pkg::FAR_IDENT_VALUE)
    else $error("wrong ident");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && !node_grp |=> reg_rdata == vncb_pkg::RESET_ZERO) else $error("reserved read");
  a_rstat_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == vncb_pkg::OFF_REMOTE_CMD |=> reg_rdata == $past(rstat))
    else $error("remote status read");
  a_am_value: assert property (@(posedge clk) disable iff (rst)
    $past(dma_busy) |-> vme_am_drive && vme_am_out == $past(am_reg)) else $error("bad modifier");
  a_vec_idle: assert property (@(posedge clk) disable iff (rst)
    !iack_cycle |=> iack_vector == 8'h00) else $error("vector outside acknowledge");
  a_send_write: assert property (@(posedge clk) disable iff (rst)
    wr_rcmd && reg_wdata[vncb_pkg::RC_SEND_DB] |=> vme_to_pci_doorbell)
    else $error("remote doorbell not written");
endmodule

// ### vncb_master.sv
// byte-wide register bus master standing in for the backplane processor
`timescale 1ns/1ps
module vncb_master
(
  input  wire logic       clk,
  output logic      [4:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // byte cycles only, never a longword
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // released lines flip so stale values cannot pass for valid ones
    reg_wdata = ~d;
    reg_addr  = ~a;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule

// ### vme_node_csr_bank_test.sv
// self-checking bench for the node register bank
`timescale 1ns/1ps
module vme_node_csr_bank_test;
  localparam int TD = 20;
  localparam int TR = 30;
  logic       clk, rst, reg_wr, reg_rd, dma_busy, remote_busy, dma_start_req;
  logic       fiber_err_pin, rbus_err_pin, inb_doorbell_pin, out_doorbell_ack_pin;
  logic       link_off_pin, remote_par_err_pin, far_doorbell_pin, ram_window_access;
  logic       vme_irq_req, pci_irq_req, iack_cycle, dma_start_ok, vme_am_drive;
  logic       ram_to_remote_reg, ram_to_local_reg, ram_to_pci, vme_irq_out, pci_irq_out;
  logic       out_doorbell_req, vme_to_pci_doorbell, far_card_clear_db, far_card_clear_par;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, vme_am_out, iack_vector, map_ram_ctl;
  int         n_mismatch, check_count, n_clr_db, n_clr_par;

  vncb_bank #(.DMA_TMO(TD), .REM_TMO(TR)) vncb_bank_i
  (
    .clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .fiber_err_pin,
    .rbus_err_pin, .inb_doorbell_pin, .out_doorbell_ack_pin, .link_off_pin,
    .remote_par_err_pin, .far_doorbell_pin, .dma_busy, .remote_busy, .dma_start_req,
    .dma_start_ok, .ram_window_access, .ram_to_remote_reg, .ram_to_local_reg, .ram_to_pci,
    .vme_am_out, .vme_am_drive, .vme_irq_req, .vme_irq_out, .iack_cycle, .iack_vector,
    .pci_irq_req, .pci_irq_out, .out_doorbell_req, .vme_to_pci_doorbell,
    .far_card_clear_db, .far_card_clear_par, .map_ram_ctl
  );
  vncb_master vncb_master_i (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

  initial clk = 1'b0;
  always #20 clk = ~clk;
  // clear strobes to the far card are pulses, so count them at the edge
  always @(posedge clk)
  begin
    if (far_card_clear_db === 1'b1) n_clr_db++;
    if (far_card_clear_par === 1'b1) n_clr_par++;
  end

  function automatic logic [7:0] rst_val(logic [4:0] a);
    if (a == vncb_pkg::OFF_IRQ_VEC) return vncb_pkg::IRQ_VEC_RESET;
    if (a == vncb_pkg::OFF_FAR_IDENT) return vncb_pkg::FAR_IDENT_VALUE;
    return vncb_pkg::RESET_ZERO;
  endfunction
  function automatic logic [7:0] rb_val(logic [4:0] a, logic [7:0] d);
    if (a == vncb_pkg::OFF_LOOPBACK) return d & vncb_pkg::LOOPBACK_MASK;
    if (a == vncb_pkg::OFF_LOCAL_CMD) return d & vncb_pkg::LOCAL_CMD_MASK;
    if (a == vncb_pkg::OFF_DMA_AM || a == vncb_pkg::OFF_IRQ_VEC) return d;
    if (a == vncb_pkg::OFF_MAP_RAM) return d;
    return rst_val(a);
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic w(logic [4:0] a, logic [7:0] d);
    vncb_master_i.wr(a, d);
  endtask
  task automatic rc(string nm, logic [4:0] a, logic [7:0] e);
    logic [7:0] d;
    vncb_master_i.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tmo(logic dma, int lim, logic [7:0] am);
    @(negedge clk);
    dma_busy    = dma;
    remote_busy = !dma;
    wait_n(lim - 8);
    if (dma) chk("am_out", am, vme_am_out);
    chk("am_drive", dma, vme_am_drive);
    rc("tmo_early", vncb_pkg::OFF_LOCAL_STAT, 8'h00);
    wait_n(8);
    rc("tmo_set", vncb_pkg::OFF_LOCAL_STAT, 8'h04);
    dma_busy    = 1'b0;
    remote_busy = 1'b0;
    wait_n(1);
    chk("am_idle", 8'h00, vme_am_out);
    w(vncb_pkg::OFF_LOCAL_CMD, 8'h80);
    rc("tmo_clr", vncb_pkg::OFF_LOCAL_STAT, 8'h00);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // generous: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    logic [7:0] v;
    rst = 1'b1;
    {reg_wr, reg_rd, dma_busy, remote_busy, dma_start_req, iack_cycle} = 6'h00;
    {fiber_err_pin, rbus_err_pin, inb_doorbell_pin, out_doorbell_ack_pin} = 4'h0;
    {link_off_pin, remote_par_err_pin, far_doorbell_pin, ram_window_access} = 4'h0;
    {vme_irq_req, pci_irq_req} = 2'b11;
    void'($urandom(38366));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int a = 0; a < 32; a++) rc("reset", 5'(a), rst_val(5'(a)));
    $display("test reset done");
    for (int a = 0; a < 32; a++)
    begin
      if (a == 3 || a == 9) continue;
      v = 8'($urandom);
      w(5'(a), v);
      rc("readback", 5'(a), rb_val(5'(a), v));
      if (5'(a) == vncb_pkg::OFF_MAP_RAM) chk("map_ctl", v, map_ram_ctl);
    end
    $display("test readback done");
    ram_window_access = 1'b1;
    dma_start_req     = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      w(vncb_pkg::OFF_LOOPBACK, 8'(m));
      chk("dma_ok", m == 0, dma_start_ok);
      // both loopbacks at once only checks the DMA refusal: steering then goes to the remote register
      if (m == 3) continue;
      chk("to_remote", m == 2, ram_to_remote_reg);
      chk("to_local", m == 1, ram_to_local_reg);
      chk("to_pci", m == 0, ram_to_pci);
    end
    w(vncb_pkg::OFF_LOOPBACK, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      w(vncb_pkg::OFF_LOCAL_CMD, {3'b000, m[1], 1'b0, m[0], 2'b00});
      chk("vme_irq", !m[1], vme_irq_out);
      chk("pci_irq", !m[0], pci_irq_out);
    end
    $display("test steering done");
    {fiber_err_pin, rbus_err_pin, inb_doorbell_pin} = 3'b111;
    wait_n(2);
    {fiber_err_pin, rbus_err_pin, inb_doorbell_pin} = 3'b000;
    wait_n(4);
    rc("sticky", vncb_pkg::OFF_LOCAL_STAT, 8'hE0);
    w(vncb_pkg::OFF_LOCAL_CMD, 8'h40);
    rc("clr_inb", vncb_pkg::OFF_LOCAL_STAT, 8'hC0);
    w(vncb_pkg::OFF_LOCAL_CMD, 8'h80);
    rc("clr_err", vncb_pkg::OFF_LOCAL_STAT, 8'h00);
    v = 8'($urandom);
    w(vncb_pkg::OFF_DMA_AM, v);
    tmo(1'b1, TD, v);
    tmo(1'b0, TR, v);
    $display("test errors done");
    w(vncb_pkg::OFF_LOCAL_CMD, 8'h20);
    chk("out_on", 1, out_doorbell_req);
    rc("out_db", vncb_pkg::OFF_LOCAL_STAT, 8'h02);
    out_doorbell_ack_pin = 1'b1;
    wait_n(5);
    out_doorbell_ack_pin = 1'b0;
    rc("out_ack", vncb_pkg::OFF_LOCAL_STAT, 8'h00);
    w(vncb_pkg::OFF_LOCAL_CMD, 8'h00);
    chk("out_off", 0, out_doorbell_req);
    w(vncb_pkg::OFF_REMOTE_CMD, 8'h20);
    chk("db_on", 1, vme_to_pci_doorbell);
    {remote_par_err_pin, far_doorbell_pin} = 2'b11;
    wait_n(5);
    rc("rstat", vncb_pkg::OFF_REMOTE_CMD, 8'h2A);
    w(vncb_pkg::OFF_REMOTE_CMD, 8'hC0);
    chk("clr_db", 1, 8'(n_clr_db));
    chk("clr_par", 1, 8'(n_clr_par));
    chk("db_off", 0, vme_to_pci_doorbell);
    {remote_par_err_pin, far_doorbell_pin} = 2'b00;
    $display("test doorbells done");
    link_off_pin = 1'b1;
    wait_n(5);
    rc("link_off", vncb_pkg::OFF_LOCAL_STAT, 8'h01);
    remote_busy = 1'b1;
    wait_n(1);
    remote_busy = 1'b0;
    rc("link_err", vncb_pkg::OFF_LOCAL_STAT, 8'h41);
    link_off_pin = 1'b0;
    wait_n(5);
    rc("link_on", vncb_pkg::OFF_LOCAL_STAT, 8'h40);
    w(vncb_pkg::OFF_LOCAL_CMD, 8'h80);
    v = 8'($urandom);
    w(vncb_pkg::OFF_IRQ_VEC, v);
    @(negedge clk);
    iack_cycle = 1'b1;
    @(negedge clk);
    iack_cycle = 1'b0;
    chk("iack_vec", v, iack_vector);
    @(negedge clk);
    chk("iack_idle", 8'h00, iack_vector);
    $display("test link and vector done");
    summarize();
  end
endmodule
